// file: design/slot_repeat_pkg.sv
// Notes on behaviour
// RULE1 - Each of the eight slots holds a two-bit repeat count v, and its entry plays v+1 times.
// RULE2 - Counts reset to zero, and a zero count plays the slot's entry once before moving on.
// RULE3 - Slot 1 uses bits 1-0 and slot 2 uses bits 3-2 of the register at offset slots_one_to_four_repeat.
// RULE4 - Slot 3 uses bits 5-4 and slot 4 uses bits 7-6 of the register at offset slots_one_to_four_repeat.
// RULE5 - Slot 5 uses bits 1-0 and slot 6 uses bits 3-2 of the register at offset slots_five_to_eight_repeat.
// RULE6 - Slot 7 uses bits 5-4 and slot 8 uses bits 7-6 of the register at offset slots_five_to_eight_repeat.
// RULE7 - Delay slots repeat too, and the sequencer moves on only after the last repetition.
// RULE8 - Every repeat field reads back the value last written, or zero after reset.
// RULE9 - On start, slots play in order from slot one up to the first zero identifier or slot eight.
// RULE10 - A set delay flag makes the seven-bit value an idle time of 10 ms per count.
// RULE11 - A pass count repeats the sequence; 7 loops until a trigger or the start bit ends it.
// RULE12 - The slot 3 field governs slot 3 itself.
// RULE13 - Repetition counts reload from their fields on every pass and every new start.
package slot_repeat_pkg;
	localparam logic [7:0] SLOTS_ONE_TO_FOUR_REPEAT_OFFSET = 8'h17;
	localparam logic [7:0] SLOTS_FIVE_TO_EIGHT_REPEAT_OFFSET = 8'h18;
	localparam logic [7:0] REPEAT_RESET_VALUE = 8'h00;
	localparam int REPEAT_FIELD_WIDTH = 2;
	localparam int SLOT_COUNT = 8;
	localparam int SLOTS_PER_REGISTER = 4;
	localparam logic [2:0] LAST_SLOT_INDEX = 3'h7;
	localparam logic [2:0] ENDLESS_PASS_COUNT = 3'h7;
	localparam int DELAY_FLAG_BIT = 7;
	localparam logic [6:0] STOP_IDENTIFIER = 7'h00;
	// Idle time per delay count, and the clock period it is counted in.
	localparam int DELAY_UNIT_MS = 10;
	localparam int CLOCK_PERIOD_PS = 5000;
	localparam longint DELAY_UNIT_PS = longint'(DELAY_UNIT_MS) * 64'd1000000000;
	localparam int DELAY_UNIT_CYCLES = int'(DELAY_UNIT_PS / CLOCK_PERIOD_PS);

	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_FETCH,
		SEQ_PLAY,
		SEQ_DELAY,
		SEQ_ADVANCE
	} seq_state_type;
endpackage

// file: design/slot_repeat_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module slot_repeat_sequencer #(
	parameter int DELAY_UNIT_CYCLES = slot_repeat_pkg::DELAY_UNIT_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input wire logic start_playback_in,
	input wire logic stop_trigger_in,
	input wire logic [2:0] sequence_pass_count_in,
	input wire logic [7:0] slot_entry_in,
	input wire logic effect_done_in,
	output logic [2:0] slot_index_out,
	output logic effect_start_out,
	output logic [6:0] slot_effect_value_out,
	output logic slot_delay_flag_out,
	output logic [1:0] repeats_left_out,
	output logic playing_out,
	output logic sequence_done_out
);
	// A zero-length tick would wrap the compare value, stretching each delay count to 2^32 cycles.
	if (DELAY_UNIT_CYCLES < 1) begin : g_bad_delay
		$error("DELAY_UNIT_CYCLES must be at least one");
	end

	logic [7:0] slots_one_to_four_repeat_reg;
	logic [7:0] slots_five_to_eight_repeat_reg;
	slot_repeat_pkg::seq_state_type state_reg;
	slot_repeat_pkg::seq_state_type state_next;
	logic start_seen_reg;
	logic [2:0] slot_reg;
	logic [1:0] repeat_left_reg;
	logic [2:0] pass_reg;
	logic [6:0] delay_left_reg;
	logic [31:0] tick_reg;
	logic start_rise;
	logic stop_now;
	logic [6:0] entry_value;
	logic entry_is_delay;
	logic entry_is_stop;
	logic last_slot;
	logic more_passes;
	logic tick_wrap;

	// Pick the two-bit count of one slot out of the two repeat registers.
	function automatic logic [1:0] slot_repeat(input logic [2:0] idx, input logic [7:0] low_reg,
			input logic [7:0] high_reg);
		logic [7:0] bank;
		logic [1:0] lane;
		bank = idx[2] ? high_reg : low_reg;
		lane = idx[1:0];
		case (lane)
			2'h0: slot_repeat = bank[1:0]; // RULE3 RULE5
			2'h1: slot_repeat = bank[3:2]; // RULE3 RULE5
			2'h2: slot_repeat = bank[5:4]; // RULE4 RULE6 RULE12
			default: slot_repeat = bank[7:6]; // RULE4 RULE6
		endcase
	endfunction

	// Decode of the entry currently presented for the selected slot.
	assign entry_value = slot_entry_in[6:0];
	assign entry_is_delay = slot_entry_in[slot_repeat_pkg::DELAY_FLAG_BIT]; // RULE10
	assign entry_is_stop = !entry_is_delay && (entry_value == slot_repeat_pkg::STOP_IDENTIFIER); // RULE9
	assign last_slot = (slot_reg == slot_repeat_pkg::LAST_SLOT_INDEX); // RULE9
	assign more_passes = (sequence_pass_count_in == slot_repeat_pkg::ENDLESS_PASS_COUNT) ||
		(pass_reg < sequence_pass_count_in); // RULE11
	assign start_rise = start_playback_in && !start_seen_reg;
	// Clearing the start bit or a trigger ends playback in any state.
	assign stop_now = !start_playback_in || stop_trigger_in; // RULE11
	assign tick_wrap = (tick_reg == 32'(DELAY_UNIT_CYCLES - 1));

	// Register writes; reserved bits do not exist, every bit is a field.
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			slots_one_to_four_repeat_reg <= slot_repeat_pkg::REPEAT_RESET_VALUE; // RULE2
			slots_five_to_eight_repeat_reg <= slot_repeat_pkg::REPEAT_RESET_VALUE; // RULE2
		end else if (reg_wr_in) begin
			if (reg_addr_in == slot_repeat_pkg::SLOTS_ONE_TO_FOUR_REPEAT_OFFSET) begin
				slots_one_to_four_repeat_reg <= reg_wdata_in; // RULE8
			end
			if (reg_addr_in == slot_repeat_pkg::SLOTS_FIVE_TO_EIGHT_REPEAT_OFFSET) begin
				slots_five_to_eight_repeat_reg <= reg_wdata_in; // RULE8
			end
		end
	end

	// Read data is registered one cycle after the read strobe; other addresses read zero.
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			if (reg_addr_in == slot_repeat_pkg::SLOTS_ONE_TO_FOUR_REPEAT_OFFSET) begin
				reg_rdata_out <= slots_one_to_four_repeat_reg; // RULE8
			end else if (reg_addr_in == slot_repeat_pkg::SLOTS_FIVE_TO_EIGHT_REPEAT_OFFSET) begin
				reg_rdata_out <= slots_five_to_eight_repeat_reg; // RULE8
			end else begin
				reg_rdata_out <= 8'h00;
			end
		end
	end

	// Edge detect on the start bit, so holding it high starts only one run.
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			start_seen_reg <= 1'b0;
		end else begin
			start_seen_reg <= start_playback_in;
		end
	end

	// Sequencer state transitions.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			slot_repeat_pkg::SEQ_IDLE: begin
				if (start_rise && !stop_trigger_in) begin
					state_next = slot_repeat_pkg::SEQ_FETCH; // RULE9
				end
			end
			slot_repeat_pkg::SEQ_FETCH: begin
				if (stop_now) begin
					state_next = slot_repeat_pkg::SEQ_IDLE;
				end else if (entry_is_stop) begin
					state_next = more_passes ? slot_repeat_pkg::SEQ_FETCH : slot_repeat_pkg::SEQ_IDLE;
				end else if (entry_is_delay) begin
					state_next = slot_repeat_pkg::SEQ_DELAY; // RULE10
				end else begin
					state_next = slot_repeat_pkg::SEQ_PLAY;
				end
			end
			slot_repeat_pkg::SEQ_PLAY: begin
				if (stop_now) begin
					state_next = slot_repeat_pkg::SEQ_IDLE;
				end else if (effect_done_in) begin
					state_next = slot_repeat_pkg::SEQ_ADVANCE;
				end
			end
			slot_repeat_pkg::SEQ_DELAY: begin
				if (stop_now) begin
					state_next = slot_repeat_pkg::SEQ_IDLE;
				end else if (delay_left_reg == 7'h00) begin
					state_next = slot_repeat_pkg::SEQ_ADVANCE; // RULE10
				end
			end
			slot_repeat_pkg::SEQ_ADVANCE: begin
				if (stop_now) begin
					state_next = slot_repeat_pkg::SEQ_IDLE;
				end else if (repeat_left_reg != 2'h0 || !last_slot || more_passes) begin
					state_next = slot_repeat_pkg::SEQ_FETCH; // RULE7 RULE11
				end else begin
					state_next = slot_repeat_pkg::SEQ_IDLE; // RULE9
				end
			end
			default: state_next = slot_repeat_pkg::SEQ_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_reg <= slot_repeat_pkg::SEQ_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Slot pointer, per-slot repetitions and pass count move together.
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			slot_reg <= 3'h0;
			repeat_left_reg <= 2'h0;
			pass_reg <= 3'h0;
		end else if (state_reg == slot_repeat_pkg::SEQ_IDLE &&
				state_next == slot_repeat_pkg::SEQ_FETCH) begin
			slot_reg <= 3'h0; // RULE9
			pass_reg <= 3'h0;
			repeat_left_reg <= slot_repeat(3'h0, slots_one_to_four_repeat_reg,
				slots_five_to_eight_repeat_reg); // RULE13
		end else if (state_reg == slot_repeat_pkg::SEQ_FETCH && entry_is_stop && more_passes &&
				!stop_now) begin
			// A zero identifier ends this pass early; the next pass restarts at slot one.
			slot_reg <= 3'h0;
			if (sequence_pass_count_in != slot_repeat_pkg::ENDLESS_PASS_COUNT) begin
				pass_reg <= pass_reg + 3'h1;
			end
			repeat_left_reg <= slot_repeat(3'h0, slots_one_to_four_repeat_reg,
				slots_five_to_eight_repeat_reg); // RULE13
		end else if (state_reg == slot_repeat_pkg::SEQ_ADVANCE &&
				state_next == slot_repeat_pkg::SEQ_FETCH) begin
			if (repeat_left_reg != 2'h0) begin
				repeat_left_reg <= repeat_left_reg - 2'h1; // RULE1 RULE7
			end else if (!last_slot) begin
				slot_reg <= slot_reg + 3'h1; // RULE2 RULE9
				repeat_left_reg <= slot_repeat(slot_reg + 3'h1, slots_one_to_four_repeat_reg,
					slots_five_to_eight_repeat_reg); // RULE13
			end else begin
				slot_reg <= 3'h0; // RULE11
				if (sequence_pass_count_in != slot_repeat_pkg::ENDLESS_PASS_COUNT) begin
					pass_reg <= pass_reg + 3'h1;
				end
				repeat_left_reg <= slot_repeat(3'h0, slots_one_to_four_repeat_reg,
					slots_five_to_eight_repeat_reg); // RULE13
			end
		end
	end

	// Delay timing: a tick of one delay unit, restarted at each fetch, and the units still to wait.
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			delay_left_reg <= 7'h00;
			tick_reg <= 32'h00000000;
		end else if (state_reg == slot_repeat_pkg::SEQ_FETCH) begin
			delay_left_reg <= entry_value; // RULE10
			tick_reg <= 32'h00000000;
		end else if (state_reg == slot_repeat_pkg::SEQ_DELAY && delay_left_reg != 7'h00) begin
			if (tick_wrap) begin
				tick_reg <= 32'h00000000;
				delay_left_reg <= delay_left_reg - 7'h01; // RULE10
			end else begin
				tick_reg <= tick_reg + 32'h00000001;
			end
		end
	end

	// Outputs toward the waveform engine; the start pulse lasts one cycle.
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			effect_start_out <= 1'b0;
			slot_effect_value_out <= 7'h00;
			slot_delay_flag_out <= 1'b0;
			sequence_done_out <= 1'b0;
		end else begin
			effect_start_out <= (state_reg == slot_repeat_pkg::SEQ_FETCH) &&
				(state_next == slot_repeat_pkg::SEQ_PLAY); // RULE7
			if (state_reg == slot_repeat_pkg::SEQ_FETCH) begin
				slot_effect_value_out <= entry_value;
				slot_delay_flag_out <= entry_is_delay;
			end
			sequence_done_out <= (state_reg != slot_repeat_pkg::SEQ_IDLE) &&
				(state_next == slot_repeat_pkg::SEQ_IDLE) && !stop_now;
		end
	end

	assign slot_index_out = slot_reg;
	assign repeats_left_out = repeat_left_reg;
	assign playing_out = (state_reg != slot_repeat_pkg::SEQ_IDLE);
endmodule
`default_nettype wire

// file: verif/slot_repeat_checker.sv
`timescale 1ns/1ps
`default_nettype none
module slot_repeat_checker (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic start_playback_in,
	input wire logic stop_trigger_in,
	input wire logic effect_start_out,
	input wire logic [2:0] slot_index_out,
	input wire logic slot_delay_flag_out,
	input wire logic playing_out,
	input wire logic sequence_done_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);
	// Only the two repeat registers decode; anything else must read as zero.
	wire logic mapped = reg_addr_in == 8'h17 || reg_addr_in == 8'h18;
	AST_START: assert property (start_playback_in && !$past(start_playback_in)
		&& !stop_trigger_in && !playing_out |=> playing_out && slot_index_out == 3'h0)
		else $error("start not taken");
	AST_DONE_IDLE: assert property (sequence_done_out |-> !playing_out)
		else $error("done while busy");
	AST_DONE_PULSE: assert property (sequence_done_out |=> !sequence_done_out)
		else $error("done long");
	AST_IDLE_QUIET: assert property (!playing_out |-> !effect_start_out)
		else $error("idle play");
	AST_PULSE: assert property (effect_start_out |=> !effect_start_out)
		else $error("start long");
	AST_EFFECT_KIND: assert property (effect_start_out |-> !slot_delay_flag_out)
		else $error("delay played");
	AST_STOP: assert property (stop_trigger_in && playing_out |-> ##[1:2] !playing_out)
		else $error("no stop");
	AST_RD_UNMAPPED: assert property (reg_rd_in && !mapped |=> reg_rdata_out == 8'h00)
		else $error("unmapped");
	AST_RD_HOLD: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
		else $error("read data moved");
	AST_WR_RD: assert property (reg_wr_in && reg_addr_in == 8'h17 ##1
		reg_rd_in && !reg_wr_in && reg_addr_in == 8'h17 |=> reg_rdata_out == $past(reg_wdata_in, 2))
		else $error("readback");
	COV_DONE: cover property (sequence_done_out);
	COV_STOP: cover property (stop_trigger_in && playing_out);
	COV_DELAY: cover property (playing_out && slot_delay_flag_out);
endmodule
bind slot_repeat_sequencer slot_repeat_checker i_chk (.ref_clk_in(ref_clk_in),
	.resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
	.reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .start_playback_in(start_playback_in),
	.stop_trigger_in(stop_trigger_in), .effect_start_out(effect_start_out),
	.slot_index_out(slot_index_out), .slot_delay_flag_out(slot_delay_flag_out),
	.playing_out(playing_out), .sequence_done_out(sequence_done_out));
`default_nettype wire

// file: verif/waveform_slot_repeat_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module waveform_slot_repeat_control_bench;
	logic ref_clk_in = 0, resetn_in = 0, reg_wr_in = 0, reg_rd_in = 0, start_playback_in = 0;
	logic stop_trigger_in = 0, effect_done_in = 0, effect_start_out, slot_delay_flag_out;
	logic playing_out, sequence_done_out;
	logic [7:0] reg_addr_in = 0, reg_wdata_in = 0, reg_rdata_out, slot_entry_in;
	logic [2:0] sequence_pass_count_in = 0, slot_index_out;
	logic [6:0] slot_effect_value_out;
	logic [1:0] repeats_left_out;
	logic [7:0] m [2];
	logic [7:0] ent [8];
	int errors = 0, n_checks = 0, seed = 32'h51DEEB5E;
	// The slot table answers combinationally, as the sequencer fetches in one cycle.
	assign slot_entry_in = ent[slot_index_out];
	// A short delay unit keeps timed delay slots cheap to simulate.
	slot_repeat_sequencer #(.DELAY_UNIT_CYCLES(4)) i_dut (.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
		.reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.start_playback_in(start_playback_in), .stop_trigger_in(stop_trigger_in),
		.sequence_pass_count_in(sequence_pass_count_in), .slot_entry_in(slot_entry_in),
		.effect_done_in(effect_done_in), .slot_index_out(slot_index_out),
		.effect_start_out(effect_start_out), .slot_effect_value_out(slot_effect_value_out),
		.slot_delay_flag_out(slot_delay_flag_out), .repeats_left_out(repeats_left_out),
		.playing_out(playing_out), .sequence_done_out(sequence_done_out));
	// Free running 200 MHz clock.
	initial begin
		forever #2.5 ref_clk_in = ~ref_clk_in;
	end
	task give_verdict;
		if (errors == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One register access; called at a falling edge, returns one cycle later with data settled.
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		reg_wr_in = w;
		reg_rd_in = !w;
		reg_addr_in = a;
		reg_wdata_in = d;
		@(negedge ref_clk_in);
		if (w && a == 8'h17) m[0] = d;
		if (w && a == 8'h18) m[1] = d;
		if (!w) chk(reg_rdata_out, (a == 8'h17) ? m[0] : (a == 8'h18) ? m[1] : 8'h00);
	endtask
	// Builds the expected play list, then answers every effect with a randomly late done.
	task automatic play(input logic [2:0] pc, input int stop_at);
		int q[$];
		int w;
		int n;
		int s;
		int e;
		bit d;
		for (int p = 0; p < ((pc == 3'h7) ? 3 : pc + 1); p++) begin
			for (s = 0; s < 8 && ent[s] != 8'h00; s++) begin
				for (int r = 0; r <= m[s / 4][2 * (s % 4) +: 2]; r++) begin
					// Repetitions still due are packed above the slot and value.
					if (!ent[s][7]) begin
						q.push_back((m[s / 4][2 * (s % 4) +: 2] - r) * 1024 + s * 128
							+ ent[s][6:0]);
					end
				end
			end
		end
		reg_wr_in = 0;
		reg_rd_in = 0;
		sequence_pass_count_in = pc;
		start_playback_in = 1;
		w = -1;
		n = 0;
		d = 0;
		repeat (3000) begin
			@(negedge ref_clk_in);
			effect_done_in = (w == 0);
			w = w - 1;
			if (effect_start_out === 1'b1) begin
				// An effect beyond the expected list compares against an impossible value.
				e = (q.size() > 0) ? q.pop_front() : -1;
				chk({repeats_left_out, slot_index_out, slot_effect_value_out}, e);
				w = $random(seed) & 3;
				n++;
			end
			if (stop_at != 0 && n == stop_at) stop_trigger_in = 1;
			if (sequence_done_out === 1'b1) d = 1;
			if (d || (stop_trigger_in && playing_out === 1'b0)) break;
		end
		chk(d, stop_at == 0);
		if (stop_at == 0) chk(q.size(), 0);
		chk(playing_out, 1'b0);
		stop_trigger_in = 0;
		start_playback_in = 0;
		effect_done_in = 0;
		repeat (3) @(negedge ref_clk_in);
	endtask
	// Watchdog well beyond the longest expected run.
	initial begin
		#200us;
		errors++;
		give_verdict;
	end
	initial begin
		m[0] = 8'h00;
		m[1] = 8'h00;
		repeat (20) @(negedge ref_clk_in);
		resetn_in = 1;
		bus(0, 8'h17, 8'h00);
		bus(0, 8'h18, 8'h00);
		// Write then read at once, with a reserved neighbour address mixed in.
		for (int i = 0; i < 9; i++) begin
			bus(1, 8'h17 + i % 3, $random(seed));
			bus(0, 8'h17 + i % 3, 8'h00);
		end
		bus(0, 8'h17, 8'h00);
		bus(0, 8'h18, 8'h00);
		ent = '{8'h05, 8'h81, 8'h09, 8'h00, 8'h22, 8'h33, 8'h44, 8'h55};
		bus(1, 8'h17, $random(seed));
		play(3'h1, 0);
		ent = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h80, 8'h06, 8'h07, 8'h7F};
		bus(1, 8'h18, 8'hFF);
		play(3'h0, 0);
		play(3'h7, 5);
		// A reset after the last run, while idle, must clear the written counts again.
		resetn_in = 0;
		@(negedge ref_clk_in);
		resetn_in = 1;
		m[0] = 8'h00;
		m[1] = 8'h00;
		bus(0, 8'h17, 8'h00);
		bus(0, 8'h18, 8'h00);
		give_verdict;
	end
endmodule
`default_nettype wire
